// ==== shared/fpd_pkg.sv ====
// fpd_pkg: constants for the fast-page dram controller
// assumes a 40 MHz controller clock and the -6 speed grade
`default_nettype none
package fpd_pkg;
  // ******************************************************
  // clock
  // ******************************************************
  localparam int CLK_PERIOD_NS = 25;
  // ******************************************************
  // geometry
  // ******************************************************
  localparam int ADDR_HALF_W = 11;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 8;
  localparam int ROW_COUNT = 2048;
  localparam int WAKE_CYCLES = 8;
  // ******************************************************
  // times in their own units
  // ******************************************************
  localparam int POWERUP_WAIT_US = 100;
  localparam int REFRESH_INTERVAL_MS = 32;
  localparam int ROW_STROBE_LOW_TIME_NS = 60;
  localparam int ROW_STROBE_LOW_MAX_NS = 10000;
  localparam int PAGE_ROW_STROBE_LOW_TIME_NS = 100000;
  localparam int RANDOM_CYCLE_TIME_NS = 110;
  localparam int ROW_PRECHARGE_TIME_NS = 40;
  localparam int ROW_TO_COLUMN_DELAY_NS = 20;
  localparam int COLUMN_STROBE_LOW_NS = 15;
  localparam int COLUMN_PRECHARGE_TIME_NS = 10;
  localparam int PAGE_CYCLE_TIME_NS = 35;
  localparam int REFRESH_COLUMN_SETUP_NS = 5;
  localparam int REFRESH_COLUMN_HOLD_NS = 15;
  localparam int REFRESH_WRITE_SELECT_SETUP_NS = 10;
  localparam int REFRESH_WRITE_SELECT_HOLD_NS = 10;
  localparam int WRITE_DATA_HOLD_NS = 10;
  localparam int WRITE_SELECT_HOLD_NS = 10;
  localparam int OUTPUT_OFF_NS = 15;
  // ******************************************************
  // cycle counts: least times round up, longest round down
  // ******************************************************
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up
  localparam int POWERUP_CYC = cyc_up(POWERUP_WAIT_US * 1000);
  localparam int REFRESH_INTERVAL_CYC = (REFRESH_INTERVAL_MS * 1000000) / CLK_PERIOD_NS;
  localparam int REFRESH_SPACING_CYC = REFRESH_INTERVAL_CYC / ROW_COUNT;
  localparam int RAS_LOW_CYC = cyc_up(ROW_STROBE_LOW_TIME_NS);
  localparam int RAS_MAX_CYC = ROW_STROBE_LOW_MAX_NS / CLK_PERIOD_NS;
  localparam int RAS_PAGE_MAX_CYC = PAGE_ROW_STROBE_LOW_TIME_NS / CLK_PERIOD_NS;
  localparam int RC_CYC = cyc_up(RANDOM_CYCLE_TIME_NS);
  localparam int RP_CYC = cyc_up(ROW_PRECHARGE_TIME_NS);
  localparam int RCD_CYC = cyc_up(ROW_TO_COLUMN_DELAY_NS);
  localparam int CAS_LOW_CYC = cyc_up(COLUMN_STROBE_LOW_NS);
  localparam int CP_CYC = cyc_up(COLUMN_PRECHARGE_TIME_NS);
  localparam int PC_CYC = cyc_up(PAGE_CYCLE_TIME_NS);
  localparam int CSR_CYC = cyc_up(REFRESH_COLUMN_SETUP_NS);
  localparam int CHR_CYC = cyc_up(REFRESH_COLUMN_HOLD_NS);
  localparam int WRP_CYC = cyc_up(REFRESH_WRITE_SELECT_SETUP_NS);
  localparam int WRH_CYC = cyc_up(REFRESH_WRITE_SELECT_HOLD_NS);
  localparam int DH_CYC = cyc_up(WRITE_DATA_HOLD_NS);
  localparam int WCH_CYC = cyc_up(WRITE_SELECT_HOLD_NS);
  localparam int OFF_CYC = cyc_up(OUTPUT_OFF_NS);
  localparam int CNT_W = 8;
  localparam int TMR_W = 16;
  // ******************************************************
  // states
  // ******************************************************
  typedef enum logic [3:0] {
    FPD_ST_POWERUP = 4'h0,
    FPD_ST_IDLE = 4'h1,
    FPD_ST_REF_SETUP = 4'h2,
    FPD_ST_REF_LOW = 4'h3,
    FPD_ST_PRECHARGE = 4'h4,
    FPD_ST_ROW = 4'h5,
    FPD_ST_COL_LOW = 4'h6,
    FPD_ST_COL_HIGH = 4'h7,
    FPD_ST_READ_DONE = 4'h8
  } fpd_state_t;
endpackage : fpd_pkg
`default_nettype wire

// ==== src/fpd_refresh_timer.sv ====
// fpd_refresh_timer: refresh pacing and interval watchdog
// assumes the controller pulses refresh_done once per refresh cycle
`timescale 1ns/100ps
`default_nettype none
module fpd_refresh_timer
  import fpd_pkg::*;
#(
  parameter int SPACING = REFRESH_SPACING_CYC,
  parameter int ROWS = ROW_COUNT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic refresh_done,
  output logic refresh_due,
  output logic interval_missed
);
  typedef struct packed {
    logic [TMR_W-1:0] tick;
    logic [TMR_W-1:0] owed;
  } fpd_rt_state_t;
  fpd_rt_state_t st_r;
  fpd_rt_state_t st_nxt;
  // ******************************************************
  // one refresh owed per spacing period
  // ******************************************************
  always_comb begin
    st_nxt = st_r;
    if (st_r.tick == TMR_W'(SPACING - 1)) begin
      st_nxt.tick = '0;
      st_nxt.owed = st_r.owed + TMR_W'(1);
    end else begin
      st_nxt.tick = st_r.tick + TMR_W'(1);
    end
    if (refresh_done && st_nxt.owed != '0) begin
      st_nxt.owed = st_nxt.owed - TMR_W'(1);
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign refresh_due = (st_r.owed != '0);
  // backlog of many rows means a row went unrefreshed for the interval
  assign interval_missed = (st_r.owed >= TMR_W'(ROWS / 2));
endmodule : fpd_refresh_timer
`default_nettype wire

// ==== src/fpd_controller.sv ====
// fpd_controller: host-side fast-page dram controller
// assumes a 4M x 8 fast-page module on the pins, -6 grade, 40 MHz clk
// Operation
// - wait 100us after power-up, then eight row-strobe refresh cycles
// - repeat the eight wake-up cycles after the refresh interval is exceeded
// - refresh all 2048 rows within every 32 ms
// - column strobe pulsed high at least 10 ns before a new cycle
// - column strobe low 5 ns before and 15 ns after row strobe falls
// - write select high 10 ns around row fall in strobe-reversed refresh
// - hidden refresh cycles row strobe with column strobe held low (not used: refresh is strobe-reversed from idle only)
// - write select returns high only after a strobe rises in reads
// - column strobe falls 20 to 45 ns after row strobe
// - row strobe low 60 ns min, 10 us single, 100 us page max
// - random cycles 110 ns apart, row strobe high at least 40 ns
// - fast-page column cycles no faster than every 35 ns
// - write data set up 0 ns before, held 10 ns after column fall
// - write select low 0 ns before and 10 ns after column fall
// - no write data driven until module outputs have floated
// - row half latched by row strobe, column half by column strobe
// - write select high reads, low writes
// - page accesses toggle column strobe within one held row
`timescale 1ns/100ps
`default_nettype none
module fpd_controller
  import fpd_pkg::*;
#(
  parameter int POWERUP_WAIT = POWERUP_CYC,
  parameter int REFRESH_SPACING = REFRESH_SPACING_CYC,
  parameter int PAGE_MAX = RAS_PAGE_MAX_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic init_done,
  output logic [ADDR_HALF_W-1:0] multiplexed_address_lines,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic write_select_n,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [DATA_W-1:0] data_lines_in
);
  typedef struct packed {
    fpd_state_t state;
    logic [TMR_W-1:0] cnt;
    logic [TMR_W-1:0] ras_cnt;
    logic [3:0] wake;
    logic init;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe;
    logic [ADDR_HALF_W-1:0] addr;
    logic [ADDR_HALF_W-1:0] open_row;
    logic [ADDR_HALF_W-1:0] col;
    logic row_open;
    logic write;
    logic [DATA_W-1:0] wdata;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
  } fpd_state_rec_t;
  fpd_state_rec_t st_r;
  fpd_state_rec_t st_nxt;
  logic refresh_due;
  logic interval_missed;
  logic refresh_done;
  logic [ADDR_HALF_W-1:0] req_row;
  logic [ADDR_HALF_W-1:0] req_col;
  logic page_hit;
  logic take;
  assign req_row = req_addr[ADDR_W-1:ADDR_HALF_W];
  assign req_col = req_addr[ADDR_HALF_W-1:0];
  fpd_refresh_timer #(
    .SPACING(REFRESH_SPACING),
    .ROWS(ROW_COUNT)
  ) u_refresh (
    .clk(clk),
    .reset_n(reset_n),
    .refresh_done(refresh_done),
    .refresh_due(refresh_due),
    .interval_missed(interval_missed)
  );
  // accept in idle, or a same-row page access while the row is open
  assign page_hit = st_r.row_open && (req_row == st_r.open_row)
    && (st_r.ras_cnt < TMR_W'(PAGE_MAX - PC_CYC - 4));
  assign take = req_valid && st_r.init && !refresh_due && !interval_missed
    && ((st_r.state == FPD_ST_IDLE)
    || (st_r.state == FPD_ST_COL_HIGH && page_hit && st_r.cnt == '0));
  assign req_ready = take;
  assign refresh_done = (st_r.state == FPD_ST_REF_LOW) && (st_r.cnt == '0);
  // ******************************************************
  // sequencer
  // ******************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.sync1 = data_lines_in;
    st_nxt.sync2 = st_r.sync1;
    if (st_nxt.ras_n == 1'b0) begin
      st_nxt.ras_cnt = st_r.ras_cnt + TMR_W'(1);
    end
    if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - TMR_W'(1);
    end
    case (st_r.state)
      FPD_ST_POWERUP: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = FPD_ST_IDLE;
        end
      end
      FPD_ST_IDLE: begin
        if (interval_missed && st_r.init) begin
          st_nxt.init = 1'b0;
          st_nxt.wake = '0;
        end else if (!st_r.init || refresh_due) begin
          // strobe-reversed refresh from idle only, never hidden
          st_nxt.state = FPD_ST_REF_SETUP;
          st_nxt.cas_n = 1'b0;
          st_nxt.we_n = 1'b1;
          st_nxt.cnt = TMR_W'(((CSR_CYC > WRP_CYC) ? CSR_CYC : WRP_CYC) - 1);
        end else if (take) begin
          st_nxt.state = FPD_ST_ROW;
          st_nxt.ras_n = 1'b0;
          st_nxt.ras_cnt = '0;
          st_nxt.addr = req_row;
          st_nxt.open_row = req_row;
          // column kept here: the request may change after it is taken
          st_nxt.col = req_col;
          st_nxt.row_open = 1'b1;
          st_nxt.write = req_write;
          st_nxt.wdata = req_wdata;
          st_nxt.we_n = !req_write;
          st_nxt.cnt = TMR_W'(RCD_CYC - 1);
        end
      end
      FPD_ST_REF_SETUP: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = FPD_ST_REF_LOW;
          st_nxt.ras_n = 1'b0;
          st_nxt.ras_cnt = '0;
          st_nxt.cnt = TMR_W'(RAS_LOW_CYC - 1);
        end
      end
      FPD_ST_REF_LOW: begin
        // row low time covers column hold and write select hold
        if (st_r.cnt == '0) begin
          st_nxt.ras_n = 1'b1;
          st_nxt.cas_n = 1'b1;
          st_nxt.state = FPD_ST_PRECHARGE;
          st_nxt.cnt = TMR_W'(RC_CYC - RAS_LOW_CYC - 1);
          if (!st_r.init) begin
            st_nxt.wake = st_r.wake + 4'h1;
            if (st_r.wake == 4'(WAKE_CYCLES - 1)) begin
              st_nxt.init = 1'b1;
            end
          end
        end
      end
      FPD_ST_ROW: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = FPD_ST_COL_LOW;
          st_nxt.cas_n = 1'b0;
          st_nxt.addr = st_r.col;
          st_nxt.oe = st_r.write;
          st_nxt.cnt = TMR_W'(((CAS_LOW_CYC > DH_CYC) ? CAS_LOW_CYC : DH_CYC) + 1);
        end else begin
          st_nxt.addr = st_r.addr;
        end
      end
      FPD_ST_COL_LOW: begin
        // wait past 15 ns column access plus two sync stages
        if (st_r.cnt == '0) begin
          if (!st_r.write) begin
            st_nxt.rd_valid = 1'b1;
            st_nxt.rd_data = st_r.sync2;
          end
          st_nxt.cas_n = 1'b1;
          st_nxt.state = FPD_ST_COL_HIGH;
          st_nxt.cnt = TMR_W'(((CP_CYC > OFF_CYC) ? CP_CYC : OFF_CYC) - 1);
        end
      end
      FPD_ST_COL_HIGH: begin
        st_nxt.oe = 1'b0;
        if (take) begin
          // same open row: next column only, page cycle spacing met
          st_nxt.state = FPD_ST_COL_LOW;
          st_nxt.cas_n = 1'b0;
          st_nxt.addr = req_col;
          st_nxt.write = req_write;
          st_nxt.wdata = req_wdata;
          st_nxt.we_n = !req_write;
          st_nxt.oe = req_write;
          st_nxt.cnt = TMR_W'(((CAS_LOW_CYC > DH_CYC) ? CAS_LOW_CYC : DH_CYC) + 1);
        end else if (st_r.cnt == '0 && st_r.ras_cnt >= TMR_W'(RAS_LOW_CYC)) begin
          st_nxt.state = FPD_ST_READ_DONE;
          st_nxt.ras_n = 1'b1;
          st_nxt.row_open = 1'b0;
          st_nxt.cnt = TMR_W'(RP_CYC - 1);
        end
      end
      FPD_ST_READ_DONE: begin
        // write select released only after both strobes are high
        st_nxt.we_n = 1'b1;
        st_nxt.state = FPD_ST_PRECHARGE;
      end
      FPD_ST_PRECHARGE: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = FPD_ST_IDLE;
        end
      end
      default: begin
        st_nxt.state = FPD_ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.state <= FPD_ST_POWERUP;
      st_r.cnt <= TMR_W'(POWERUP_WAIT - 1);
      st_r.ras_n <= 1'b1;
      st_r.cas_n <= 1'b1;
      st_r.we_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ******************************************************
  // outputs
  // ******************************************************
  assign multiplexed_address_lines = st_r.addr;
  assign row_strobe_n = st_r.ras_n;
  assign column_strobe_n = st_r.cas_n;
  assign write_select_n = st_r.we_n;
  assign data_lines_out = st_r.wdata;
  assign data_lines_oe = st_r.oe;
  assign rd_valid = st_r.rd_valid;
  assign rd_data = st_r.rd_data;
  assign init_done = st_r.init;
endmodule : fpd_controller
`default_nettype wire

// ==== verification/fpd_controller_sva.sv ====
// fpd_controller_sva: pin timing checks for the dram controller
// assumes the 40 MHz clock and registered pin outputs
`timescale 1ns/100ps
`default_nettype none
module fpd_controller_sva
  import fpd_pkg::*;
#(
  parameter int POWERUP_WAIT = POWERUP_CYC,
  parameter int REFRESH_SPACING = REFRESH_SPACING_CYC,
  parameter int PAGE_MAX = RAS_PAGE_MAX_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic rd_valid,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic init_done,
  input wire logic [ADDR_HALF_W-1:0] multiplexed_address_lines,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_select_n,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe,
  input wire logic [DATA_W-1:0] data_lines_in
);
  // ******************************************************
  // helper counters
  // ******************************************************
  int up_cnt, wake_cnt, low_cnt, gap_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_cnt <= 0;
      wake_cnt <= 0;
      low_cnt <= 0;
      gap_cnt <= 0;
    end else begin
      up_cnt <= up_cnt + 1;
      wake_cnt <= wake_cnt + int'($fell(row_strobe_n) && !column_strobe_n);
      low_cnt <= row_strobe_n ? 0 : low_cnt + 1;
      gap_cnt <= (($fell(row_strobe_n) && !column_strobe_n) || !init_done) ? 0 : gap_cnt + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence ref_edge;
    $fell(row_strobe_n) && !column_strobe_n;
  endsequence
  sequence ref_setup;
    !$past(column_strobe_n) && $past(write_select_n) && write_select_n;
  endsequence
  sequence ref_hold;
    !column_strobe_n && write_select_n;
  endsequence
  sequence row_edge;
    $fell(row_strobe_n) && column_strobe_n;
  endsequence
  sequence col_edge;
    $fell(column_strobe_n) && !row_strobe_n;
  endsequence
  sequence write_edge;
    $fell(column_strobe_n) && !write_select_n;
  endsequence
  sequence write_hold;
    !write_select_n && data_lines_oe && $stable(data_lines_out);
  endsequence
  sequence read_seen;
    $past(write_select_n, 3) && !$past(column_strobe_n, 3);
  endsequence
  sequence wake_done;
    wake_cnt >= WAKE_CYCLES && up_cnt >= POWERUP_WAIT;
  endsequence
  // ******************************************************
  // assertions
  // ******************************************************
  ras_low_min_a: assert property ($fell(row_strobe_n) |-> !row_strobe_n [*3])
    else $error("row strobe low too short");
  ras_high_min_a: assert property ($rose(row_strobe_n) |-> row_strobe_n [*2])
    else $error("row strobe precharge too short");
  ras_low_max_a: assert property (low_cnt <= PAGE_MAX)
    else $error("row strobe low too long");
  cas_delay_a: assert property (col_edge |-> !$past(row_strobe_n))
    else $error("column strobe too soon after row");
  cas_window_a: assert property (row_edge |-> ##1 $fell(column_strobe_n))
    else $error("column strobe late after row");
  refresh_order_a: assert property (ref_edge |-> ref_setup ##1 ref_hold)
    else $error("refresh strobe order broken");
  early_write_a: assert property (write_edge |-> data_lines_oe ##1 write_hold)
    else $error("write data or select not held");
  oe_write_only_a: assert property (data_lines_oe |-> !write_select_n && !row_strobe_n)
    else $error("data driven outside a write");
  read_data_a: assert property (rd_valid |-> read_seen)
    else $error("read data without a read cycle");
  ready_init_a: assert property (req_ready |-> init_done)
    else $error("request taken before wake-up");
  wake_seq_a: assert property ($rose(init_done) |-> wake_done)
    else $error("wake-up sequence incomplete");
  refresh_pace_a: assert property (gap_cnt <= 2 * REFRESH_SPACING)
    else $error("refresh overdue");
endmodule : fpd_controller_sva
bind fpd_controller fpd_controller_sva #(.POWERUP_WAIT(POWERUP_WAIT),
  .REFRESH_SPACING(REFRESH_SPACING), .PAGE_MAX(PAGE_MAX)) i_sva (.clk(clk), .reset_n(reset_n),
  .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
  .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done),
  .multiplexed_address_lines(multiplexed_address_lines), .row_strobe_n(row_strobe_n),
  .column_strobe_n(column_strobe_n), .write_select_n(write_select_n),
  .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .data_lines_in(data_lines_in));
`default_nettype wire

// ==== verification/fpd_dram_model.sv ====
// fpd_dram_model: behavioural fast-page dram module
// assumes registered controller pins; answers 1 ns plus ACCESS_NS after column fall
`timescale 1ns/100ps
`default_nettype none
module fpd_dram_model
  import fpd_pkg::*;
#(
  parameter int ACCESS_NS = 10
) (
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_select_n,
  input wire logic [ADDR_HALF_W-1:0] multiplexed_address_lines,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe,
  output logic [DATA_W-1:0] data_lines_in,
  output int refreshes
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_HALF_W-1:0] row;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] q, last;
  logic drv;
  initial begin
    refreshes = 0;
    drv = 1'b0;
    last = '0;
    q = '0;
  end
  // pins settle just after the clock edge
  always @(negedge row_strobe_n) begin
    #1;
    if (column_strobe_n) row = multiplexed_address_lines;
    else if (write_select_n) refreshes++;
  end
  always @(negedge column_strobe_n) begin
    #1;
    a = {row, multiplexed_address_lines};
    if (!row_strobe_n && !write_select_n) mem[a] = data_lines_out;
    else if (!row_strobe_n) begin
      q = mem.exists(a) ? mem[a] : ~last;
      #(ACCESS_NS);
      drv = !column_strobe_n;
    end
  end
  always @(posedge column_strobe_n) begin
    if (drv) last = q;
    drv = 1'b0;
  end
  // released lines show the inverse of the last value
  assign data_lines_in = data_lines_oe ? data_lines_out : (drv ? q : ~last);
endmodule : fpd_dram_model
`default_nettype wire

// ==== verification/testbench.sv ====
// testbench: table-driven reads and writes through the controller
// assumes fpd_dram_model on the pins and the bound checker
`timescale 1ns/100ps
`default_nettype none
module testbench import fpd_pkg::*;;
  typedef struct {logic w; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;} fpd_row_t;
  logic clk, reset_n, req_valid, req_ready, req_write, rd_valid, init_done;
  logic row_strobe_n, column_strobe_n, write_select_n, data_lines_oe;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, rd_data, data_lines_out, data_lines_in;
  logic [ADDR_HALF_W-1:0] multiplexed_address_lines;
  int errors, total_checks, refreshes, n0;
  // write rows carry data, read rows the expected data
  fpd_row_t rows [8] = '{'{1'b1, 22'h002803, 8'h5A}, '{1'b1, 22'h002804, 8'hC3},
    '{1'b1, 22'h3FFFFF, 8'h81}, '{1'b0, 22'h002803, 8'h5A}, '{1'b0, 22'h002804, 8'hC3},
    '{1'b0, 22'h3FFFFF, 8'h81}, '{1'b1, 22'h000000, 8'hFF}, '{1'b0, 22'h000000, 8'hFF}};
  fpd_controller #(.POWERUP_WAIT(20), .REFRESH_SPACING(40)) i_dut (.clk(clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done),
    .multiplexed_address_lines(multiplexed_address_lines), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_select_n(write_select_n),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .data_lines_in(data_lines_in));
  fpd_dram_model i_mem (.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_select_n(write_select_n), .multiplexed_address_lines(multiplexed_address_lines),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .data_lines_in(data_lines_in), .refreshes(refreshes));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic print_verdict;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic send(input fpd_row_t r);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= r.w;
    req_addr <= r.a;
    req_wdata <= r.d;
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 400);
    chk(n < 400, "request not taken");
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : send
  task automatic rd_wait(input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rd_valid !== 1'b1 && n < 100);
    chk(rd_valid === 1'b1 && rd_data === exp, "read data mismatch");
  endtask : rd_wait
  task automatic wait_init;
    int n, r0;
    n = 0;
    r0 = refreshes;
    while (init_done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(init_done === 1'b1 && n >= 20 && refreshes - r0 >= WAKE_CYCLES,
      "wake-up sequence");
  endtask : wait_init
  task automatic chk_reset;
    chk(row_strobe_n === 1'b1 && column_strobe_n === 1'b1 && write_select_n === 1'b1
      && data_lines_oe === 1'b0 && init_done === 1'b0 && req_ready === 1'b0, "reset pins");
  endtask : chk_reset
  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    errors = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    chk_reset();
    reset_n <= 1'b1;
    wait_init();
    foreach (rows[i]) begin
      send(rows[i]);
      if (!rows[i].w) rd_wait(rows[i].d);
    end
    // two reads back to back in one open row: page read
    send(rows[3]);
    send(rows[4]);
    rd_wait(rows[4].d);
    n0 = refreshes;
    repeat (200) @(posedge clk);
    chk(refreshes - n0 >= 4, "refresh pace");
    // reset in the middle of a read
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= 1'b0;
    req_addr <= rows[5].a;
    repeat (4) @(posedge clk);
    reset_n <= 1'b0;
    req_valid <= 1'b0;
    @(negedge clk);
    chk_reset();
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    wait_init();
    send(rows[5]);
    rd_wait(rows[5].d);
    print_verdict();
  end
  initial begin
    #(CLK_PERIOD_NS * 20000);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
